// ==== hw/aspg_core.sv ====
// Single-axis speed profile generator with an Avalon-MM register slave.
// Assumes one 20 MHz clock core_clk and a synchronous active-low reset;
// the host is an Avalon-MM master honouring waitrequest.
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps

module aspg_core
  import aspg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             pulse_out,
  output logic             busy
);

  aspg_speed_set_t pre_set;
  aspg_speed_set_t act_set;
  aspg_state_t     state_q;
  logic [2:0]      mode_q;
  logic            bus_ack;
  logic            wr_take;
  logic            cmd_wr;
  logic [7:0]      cmd_code;
  logic            start_ok;
  logic            posn_q;
  logic            manual_q;
  logic            curve_q;
  logic [15:0]     speed_q;
  logic [15:0]     accum_q;
  logic [16:0]     accum_sum;
  logic [11:0]     div_q;
  logic            tick;
  logic            pulse_hit;
  logic [27:0]     remain_q;
  logic [19:0]     step_q;
  logic [19:0]     step_len;
  logic            step_hit;
  logic [15:0]     dr_eff;
  logic [16:0]     span_a;
  logic [16:0]     span_d;
  logic            in_s_zone;
  logic [46:0]     wsum_q;
  logic            rdown_hit;
  logic signed [29:0] auto_left;
  logic signed [47:0] auto_lhs;
  logic            last_pulse;

  // Avalon-MM slave: every access sees one wait state; a write lands only at
  // the edge that samples waitrequest low, so an access is never half taken.
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
  assign wr_take         = avs_write & bus_ack;
  assign cmd_wr          = wr_take && (avs_address == `ASPG_OFS_COMMAND);
  assign cmd_code        = avs_writedata[7:0];
  assign start_ok        = (state_q == ST_IDLE);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      bus_ack <= 1'b0;
    else
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
  end

  // Preregister writes; values stay until rewritten.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pre_set.move_amount        <= `ASPG_RST_MOVE_AMOUNT;
      pre_set.low_speed_value    <= `ASPG_RST_SPEED;
      pre_set.high_speed_value   <= `ASPG_RST_SPEED;
      pre_set.accel_rate         <= `ASPG_RST_RATE;
      pre_set.decel_rate         <= `ASPG_RST_DECEL_RATE;
      pre_set.speed_multiplier   <= `ASPG_RST_MULTIPLIER;
      pre_set.ramp_down_point    <= `ASPG_RST_RAMP_POINT;
      pre_set.scurve_accel_range <= `ASPG_RST_SPAN;
      pre_set.scurve_decel_range <= `ASPG_RST_SPAN;
      mode_q                     <= `ASPG_RST_MODE;
    end
    else if (wr_take)
    begin
      if (avs_address == `ASPG_OFS_MOVE_AMOUNT)
        pre_set.move_amount <= avs_writedata[27:0];
      else if (avs_address == `ASPG_OFS_LOW_SPEED)
        pre_set.low_speed_value <= avs_writedata[15:0];
      else if (avs_address == `ASPG_OFS_HIGH_SPEED)
        pre_set.high_speed_value <= avs_writedata[15:0];
      else if (avs_address == `ASPG_OFS_ACCEL_RATE)
        pre_set.accel_rate <= avs_writedata[15:0];
      else if (avs_address == `ASPG_OFS_DECEL_RATE)
        pre_set.decel_rate <= avs_writedata[15:0];
      else if (avs_address == `ASPG_OFS_MULTIPLIER)
        pre_set.speed_multiplier <= avs_writedata[11:0];
      else if (avs_address == `ASPG_OFS_RAMP_POINT)
        pre_set.ramp_down_point <= avs_writedata[23:0];
      else if (avs_address == `ASPG_OFS_ACCEL_SPAN)
        pre_set.scurve_accel_range <= avs_writedata[14:0];
      else if (avs_address == `ASPG_OFS_DECEL_SPAN)
        pre_set.scurve_decel_range <= avs_writedata[14:0];
      else if (avs_address == `ASPG_OFS_MODE)
        mode_q <= avs_writedata[2:0];
    end
  end

  // Read data is captured in the wait cycle and stands at the release edge.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !bus_ack)
    begin
      if (avs_address == `ASPG_OFS_MOVE_AMOUNT)
        avs_readdata <= {4'h0, pre_set.move_amount};
      else if (avs_address == `ASPG_OFS_LOW_SPEED)
        avs_readdata <= {16'h0000, pre_set.low_speed_value};
      else if (avs_address == `ASPG_OFS_HIGH_SPEED)
        avs_readdata <= {16'h0000, pre_set.high_speed_value};
      else if (avs_address == `ASPG_OFS_ACCEL_RATE)
        avs_readdata <= {16'h0000, pre_set.accel_rate};
      else if (avs_address == `ASPG_OFS_DECEL_RATE)
        avs_readdata <= {16'h0000, pre_set.decel_rate};
      else if (avs_address == `ASPG_OFS_MULTIPLIER)
        avs_readdata <= {20'h0_0000, pre_set.speed_multiplier};
      else if (avs_address == `ASPG_OFS_RAMP_POINT)
        avs_readdata <= {8'h00, pre_set.ramp_down_point};
      else if (avs_address == `ASPG_OFS_ACCEL_SPAN)
        avs_readdata <= {17'h0_0000, pre_set.scurve_accel_range};
      else if (avs_address == `ASPG_OFS_DECEL_SPAN)
        avs_readdata <= {17'h0_0000, pre_set.scurve_decel_range};
      else if (avs_address == `ASPG_OFS_MODE)
        avs_readdata <= {29'h0000_0000, mode_q};
      else if (avs_address == `ASPG_OFS_STATUS)
        avs_readdata <= {28'h000_0000, state_q, busy};
      else if (avs_address == `ASPG_OFS_SPEED_NOW)
        avs_readdata <= {16'h0000, speed_q};
      else if (avs_address == `ASPG_OFS_REMAIN)
        avs_readdata <= {4'h0, remain_q};
      else
        avs_readdata <= 32'h0000_0000;
    end
  end

  // A start command freezes the preregisters into the active set.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      act_set  <= '0;
      posn_q   <= 1'b0;
      manual_q <= 1'b0;
      curve_q  <= 1'b0;
    end
    else if (cmd_wr && start_ok && cmd_code >= `ASPG_CMD_CONST_LOW
             && cmd_code <= `ASPG_CMD_VARIED_TWO)
    begin
      act_set  <= pre_set;
      posn_q   <= mode_q[`ASPG_MODE_POSITIONING];
      curve_q  <= mode_q[`ASPG_MODE_CURVE_S];
      manual_q <= mode_q[`ASPG_MODE_RAMP_MANUAL]
                  || (cmd_code == `ASPG_CMD_VARIED_ONE);
    end
  end

  // Rate tick: one per (multiplier + 1) reference clocks.
  assign tick = (div_q >= act_set.speed_multiplier);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || state_q == ST_IDLE)
      div_q <= 12'h000;
    else if (tick)
      div_q <= 12'h000;
    else
      div_q <= div_q + 12'h001;
  end

  // Speed accumulates per tick; each overflow is one output pulse.
  assign accum_sum = {1'b0, accum_q} + {1'b0, speed_q};
  assign pulse_hit = tick && accum_sum[16] && (state_q != ST_IDLE);
  assign last_pulse = posn_q && pulse_hit && (remain_q == 28'h000_0001);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || state_q == ST_IDLE)
      accum_q <= 16'h0000;
    else if (tick)
      accum_q <= accum_sum[15:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pulse_out <= 1'b0;
    else
      pulse_out <= pulse_hit;
  end

  // Remaining count is the magnitude of the signed move amount.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      remain_q <= 28'h000_0000;
    else if (cmd_wr && start_ok)
      remain_q <= pre_set.move_amount[27] ? 28'(-pre_set.move_amount)
                                          : pre_set.move_amount;
    else if (posn_q && pulse_hit && remain_q != 28'h000_0000)
      remain_q <= remain_q - 28'h000_0001;
  end

  // Ramp timing: zero decel rate falls back to the accel rate.
  assign dr_eff = (act_set.decel_rate == 16'h0000) ? act_set.accel_rate
                                                   : act_set.decel_rate;
  assign span_a = (act_set.scurve_accel_range == 15'h0000)
                ? 17'((act_set.high_speed_value - act_set.low_speed_value) >> 1)
                : {2'b00, act_set.scurve_accel_range};
  assign span_d = (act_set.scurve_decel_range == 15'h0000)
                ? 17'((act_set.high_speed_value - act_set.low_speed_value) >> 1)
                : {2'b00, act_set.scurve_decel_range};

  // S spans step at half the linear slope, which gives the quoted times.
  always_comb
  begin
    in_s_zone = 1'b0;
    if (curve_q && state_q == ST_ACCEL)
      in_s_zone = ({1'b0, speed_q} < {1'b0, act_set.low_speed_value} + span_a)
               || ({1'b0, speed_q} + span_a >= {1'b0, act_set.high_speed_value});
    else if (curve_q && state_q == ST_DECEL)
      in_s_zone = ({1'b0, speed_q} + span_d > {1'b0, act_set.high_speed_value})
               || ({1'b0, speed_q} <= {1'b0, act_set.low_speed_value} + span_d);
  end

  always_comb
  begin
    if (state_q == ST_DECEL)
      step_len = 20'({4'h0, dr_eff} + 20'h0_0001);
    else
      step_len = 20'({4'h0, act_set.accel_rate} + 20'h0_0001);
    if (in_s_zone)
      step_len = 20'(step_len * `ASPG_STEP_SCURVE);
    else
      step_len = 20'(step_len * `ASPG_STEP_LINEAR);
  end

  assign step_hit = (step_q >= step_len - 20'h0_0001);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !(state_q == ST_ACCEL || state_q == ST_DECEL) || step_hit)
      step_q <= 20'h0_0000;
    else
      step_q <= step_q + 20'h0_0001;
  end

  // Weighted pulse count during acceleration predicts deceleration length.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || state_q == ST_IDLE)
      wsum_q <= '0;
    else if (state_q == ST_ACCEL && pulse_hit)
      wsum_q <= wsum_q + {31'h0000_0000, dr_eff} + 47'h0000_0000_0001;
  end

  assign auto_left = $signed({2'b00, remain_q})
                   - 30'($signed(act_set.ramp_down_point));
  assign auto_lhs  = 48'(auto_left * $signed({2'b00, act_set.accel_rate} + 18'h0_0001));

  always_comb
  begin
    if (manual_q)
      rdown_hit = ({4'h0, act_set.ramp_down_point} >= remain_q);
    else
      rdown_hit = (auto_lhs <= $signed({1'b0, wsum_q}));
  end

  // Profile state machine.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      speed_q <= 16'h0000;
    end
    else if (cmd_wr && cmd_code == `ASPG_CMD_STOP_NOW)
    begin
      state_q <= ST_IDLE;
      speed_q <= 16'h0000;
    end
    else if (last_pulse)
    begin
      state_q <= ST_IDLE;
      speed_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (cmd_wr && cmd_code == `ASPG_CMD_CONST_LOW)
          begin
            state_q <= ST_CONST;
            speed_q <= pre_set.low_speed_value;
          end
          else if (cmd_wr && cmd_code == `ASPG_CMD_CONST_HIGH)
          begin
            state_q <= ST_CONST;
            speed_q <= pre_set.high_speed_value;
          end
          else if (cmd_wr && cmd_code == `ASPG_CMD_VARIED_ONE
                   && mode_q[`ASPG_MODE_POSITIONING]
                   && pre_set.ramp_down_point == 24'h00_0000)
            state_q <= ST_IDLE;
          else if (cmd_wr && (cmd_code == `ASPG_CMD_VARIED_ONE
                              || cmd_code == `ASPG_CMD_VARIED_TWO))
          begin
            state_q <= ST_ACCEL;
            speed_q <= pre_set.low_speed_value;
          end
        ST_CONST:
          if (cmd_wr && cmd_code == `ASPG_CMD_STOP_DECEL)
          begin
            if (speed_q > act_set.low_speed_value)
              state_q <= ST_DECEL;
            else
            begin
              state_q <= ST_IDLE;
              speed_q <= 16'h0000;
            end
          end
        ST_ACCEL, ST_TOP:
          if ((cmd_wr && cmd_code == `ASPG_CMD_STOP_DECEL)
              || (posn_q && rdown_hit))
            state_q <= ST_DECEL;
          else if (state_q == ST_ACCEL
                   && speed_q >= act_set.high_speed_value)
          begin
            state_q <= ST_TOP;
            speed_q <= act_set.high_speed_value;
          end
          else if (state_q == ST_ACCEL && step_hit)
            speed_q <= speed_q + 16'h0001;
        ST_DECEL:
          if (speed_q <= act_set.low_speed_value)
          begin
            speed_q <= act_set.low_speed_value;
            state_q <= posn_q ? ST_TAIL : ST_IDLE;
          end
          else if (step_hit)
            speed_q <= speed_q - 16'h0001;
        ST_TAIL:
          if (cmd_wr && cmd_code == `ASPG_CMD_STOP_DECEL)
          begin
            state_q <= ST_IDLE;
            speed_q <= 16'h0000;
          end
        default:
        begin
          state_q <= ST_IDLE;
          speed_q <= 16'h0000;
        end
      endcase
    end
  end

  assign busy = (state_q != ST_IDLE);

endmodule // aspg_core

// ==== hw/aspg_regs.svh ====
// Register offsets, field positions, reset values and timing factors of the
// axis speed profile generator. Definitions only; included by the package.
`ifndef ASPG_REGS_SVH
`define ASPG_REGS_SVH

// Byte addresses on the Avalon-MM register bus.
`define ASPG_OFS_MOVE_AMOUNT   6'h00
`define ASPG_OFS_LOW_SPEED     6'h04
`define ASPG_OFS_HIGH_SPEED    6'h08
`define ASPG_OFS_ACCEL_RATE    6'h0C
`define ASPG_OFS_DECEL_RATE    6'h10
`define ASPG_OFS_MULTIPLIER    6'h14
`define ASPG_OFS_RAMP_POINT    6'h18
`define ASPG_OFS_ACCEL_SPAN    6'h1C
`define ASPG_OFS_DECEL_SPAN    6'h20
`define ASPG_OFS_MODE          6'h24
`define ASPG_OFS_COMMAND       6'h28
`define ASPG_OFS_STATUS        6'h2C
`define ASPG_OFS_SPEED_NOW     6'h30
`define ASPG_OFS_REMAIN        6'h34

// Fields of the operation mode register.
`define ASPG_MODE_POSITIONING  0
`define ASPG_MODE_RAMP_MANUAL  1
`define ASPG_MODE_CURVE_S      2

// Command codes written to the command register.
`define ASPG_CMD_STOP_NOW      8'h49
`define ASPG_CMD_STOP_DECEL    8'h4A
`define ASPG_CMD_CONST_LOW     8'h50
`define ASPG_CMD_CONST_HIGH    8'h51
`define ASPG_CMD_VARIED_ONE    8'h52
`define ASPG_CMD_VARIED_TWO    8'h53

// Reset values of the preregisters.
`define ASPG_RST_MOVE_AMOUNT   28'h000_0000
`define ASPG_RST_SPEED         16'h0001
`define ASPG_RST_RATE          16'h0001
`define ASPG_RST_DECEL_RATE    16'h0000
`define ASPG_RST_MULTIPLIER    12'h002
`define ASPG_RST_RAMP_POINT    24'h00_0000
`define ASPG_RST_SPAN          15'h0000
`define ASPG_RST_MODE          3'h0

// Reference clock cycles per speed step, per unit of (rate + 1).
`define ASPG_STEP_LINEAR       4
`define ASPG_STEP_SCURVE       8

`endif

// ==== hw/aspg_pkg.sv ====
// Types shared by the axis speed profile generator.
// Assumes the constant header aspg_regs.svh sits beside this file.
`include "aspg_regs.svh"

package aspg_pkg;

  typedef struct packed {
    logic [27:0] move_amount;
    logic [15:0] low_speed_value;
    logic [15:0] high_speed_value;
    logic [15:0] accel_rate;
    logic [15:0] decel_rate;
    logic [11:0] speed_multiplier;
    logic [23:0] ramp_down_point;
    logic [14:0] scurve_accel_range;
    logic [14:0] scurve_decel_range;
  } aspg_speed_set_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONST,
    ST_ACCEL,
    ST_TOP,
    ST_DECEL,
    ST_TAIL
  } aspg_state_t;

endpackage

// ==== verif/aspg_core_props.sv ====
// Concurrent checks on the ports of aspg_core, bound to every instance.
// Assumes one clock domain and the register header on the include path.
`timescale 1ns/1ps
`include "aspg_regs.svh"

module aspg_core_props (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        pulse_out,
  input wire logic        busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic req;
  logic cmd_c0;
  assign req    = avs_read || avs_write;
  assign cmd_c0 = avs_write && !avs_waitrequest && avs_address == `ASPG_OFS_COMMAND;

  property p_wait_first;
    $rose(req) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("new access without a wait state");

  property p_wait_one;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("access held longer than one wait state");

  property p_wait_idle;
    !req |-> !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest high without a request");

  property p_start;
    cmd_c0 && !busy && avs_writedata[7:1] == 7'h28 |=> busy;
  endproperty
  a_start: assert property (p_start)
    else $error("constant speed start not taken");

  property p_busy_cause;
    $rose(busy) |-> $past(cmd_c0);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("profile started without a command");

  property p_stop_now;
    cmd_c0 && avs_writedata[7:0] == `ASPG_CMD_STOP_NOW |=> !busy ##1 !pulse_out [*4];
  endproperty
  a_stop_now: assert property (p_stop_now)
    else $error("output continued after immediate stop");

  property p_pulse_gap;
    pulse_out |=> !pulse_out [*2];
  endproperty
  a_pulse_gap: assert property (p_pulse_gap)
    else $error("pulses closer than one multiplier tick");

  property p_idle_quiet;
    !busy && !$past(busy) |-> !pulse_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("pulse while idle");

  c_start: cover property (cmd_c0 && !busy);
  c_end: cover property ($fell(busy));
  c_pulses: cover property (pulse_out ##[1:30] pulse_out);
endmodule // aspg_core_props

bind aspg_core aspg_core_props props_u (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .pulse_out(pulse_out),
  .busy(busy)
);

// ==== verif/aspg_host_model.sv ====
// Host side of the register bus: an Avalon-MM master driven by bench calls.
// Assumes calls are made just after a rising edge of core_clk.
`timescale 1ns/1ps

module aspg_host_model (
  input  wire logic        core_clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic      [5:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata
);
  initial
  begin
    avs_address   = 6'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
  end

  // The request stands until an edge samples waitrequest low; read data is
  // taken at that edge, before the edge's own updates land.
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    q = avs_readdata;
    avs_write     <= 1'b0;
    avs_read      <= 1'b0;
    avs_writedata <= ~d;
    @(posedge core_clk);
  endtask
endmodule // aspg_host_model

// ==== verif/tb_axis_speed_profile_generator.sv ====
// Self-checking bench for the axis speed profile generator core.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/1ps
`include "aspg_regs.svh"

module tb_axis_speed_profile_generator;
  typedef struct {
    logic [5:0]  a;
    logic [31:0] rv;
    logic [31:0] msk;
  } aspg_row_t;

  logic        core_clk;
  logic        rst_n;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pulse_out;
  logic        busy;
  logic [31:0] q;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          pulses = 0;
  int          gap = 0;
  int          lastp = 0;
  int          t0;
  int          p0;
  aspg_row_t   rows[11];
  logic [2:0]  curve[3] = '{3'h0, 3'h4, 3'h4};
  logic [14:0] span[3] = '{15'h0000, 15'h0000, 15'h0002};
  int          acc[3] = '{64, 128, 96};

  aspg_core dut_u (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pulse_out(pulse_out), .busy(busy));

  aspg_host_model host_u (.core_clk(core_clk), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (pulse_out === 1'b1)
    begin
      pulses <= pulses + 1;
      gap    <= cyc - lastp;
      lastp  <= cyc;
    end
  end

  task automatic stop_test();
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_near(input int got, input int exp, input int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol)
    begin
      bad_count++;
      $display("unexpected at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a);
    host_u.xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  task automatic cmd(input logic [7:0] c);
    wr(`ASPG_OFS_COMMAND, {24'h00_0000, c});
  endtask

  task automatic poll(input logic [2:0] want);
    int n;
    n = 0;
    rd(`ASPG_OFS_STATUS);
    while (q[3:1] !== want && n < 900)
    begin
      rd(`ASPG_OFS_STATUS);
      n++;
    end
    if (q[3:1] !== want)
    begin
      bad_count++;
      $display("unexpected at %0t: state %0d never reached", $time, want);
    end
  endtask

  // Low speed 2000h, accel rate 1, decel rate 0, multiplier 2 throughout.
  task automatic cfg(input logic [2:0] md, input logic [15:0] hi, input logic [14:0] sp,
                     input logic [27:0] mv, input logic [23:0] rp);
    wr(`ASPG_OFS_MODE, {29'h0000_0000, md});
    wr(`ASPG_OFS_LOW_SPEED, 32'h0000_2000);
    wr(`ASPG_OFS_HIGH_SPEED, {16'h0000, hi});
    wr(`ASPG_OFS_ACCEL_RATE, 32'h0000_0001);
    wr(`ASPG_OFS_DECEL_RATE, 32'h0000_0000);
    wr(`ASPG_OFS_MULTIPLIER, 32'h0000_0002);
    wr(`ASPG_OFS_ACCEL_SPAN, {17'h0_0000, sp});
    wr(`ASPG_OFS_DECEL_SPAN, {17'h0_0000, sp});
    wr(`ASPG_OFS_MOVE_AMOUNT, {4'h0, mv});
    wr(`ASPG_OFS_RAMP_POINT, {8'h00, rp});
  endtask

  initial
  begin
    #1_000_000;
    bad_count++;
    stop_test();
  end

  initial
  begin
    rst_n = 1'b0;
    rows = '{'{6'h00, 0, 32'h0FFF_FFFF}, '{6'h04, 1, 32'h0000_FFFF},
             '{6'h08, 1, 32'h0000_FFFF}, '{6'h0C, 1, 32'h0000_FFFF},
             '{6'h10, 0, 32'h0000_FFFF}, '{6'h14, 2, 32'h0000_0FFF},
             '{6'h18, 0, 32'h00FF_FFFF}, '{6'h1C, 0, 32'h0000_7FFF},
             '{6'h20, 0, 32'h0000_7FFF}, '{6'h24, 0, 32'h0000_0007},
             '{6'h3C, 0, 32'h0000_0000}};
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk(q, rows[i].rv);
      wr(rows[i].a, 32'hFFFF_FFFF);
      rd(rows[i].a);
      chk(q, rows[i].msk);
    end
    cfg(3'h1, 16'h4000, 15'h0000, 28'h000_0004, 24'h00_0000);
    p0 = pulses;
    cmd(`ASPG_CMD_CONST_LOW);
    poll(3'h0);
    chk_near(pulses - p0, 4, 0);
    chk_near(gap, 24, 0);
    wr(`ASPG_OFS_MOVE_AMOUNT, 32'h0000_0003);
    p0 = pulses;
    cmd(`ASPG_CMD_CONST_HIGH);
    poll(3'h0);
    chk_near(pulses - p0, 3, 0);
    chk_near(gap, 12, 0);
    wr(`ASPG_OFS_MODE, 32'h0000_0000);
    cmd(`ASPG_CMD_CONST_HIGH);
    repeat (60) @(posedge core_clk);
    cmd(`ASPG_CMD_STOP_NOW);
    p0 = pulses;
    chk({31'h0000_0000, busy}, 32'h0000_0000);
    repeat (30) @(posedge core_clk);
    chk_near(pulses - p0, 0, 0);
    cfg(3'h1, 16'h4000, 15'h0000, 28'h000_0004, 24'h00_0000);
    p0 = pulses;
    cmd(`ASPG_CMD_VARIED_ONE);
    repeat (30) @(posedge core_clk);
    chk({31'h0000_0000, busy}, 32'h0000_0000);
    chk_near(pulses - p0, 0, 0);
    for (int i = 0; i < 3; i++)
    begin
      cfg(curve[i], 16'h2008, span[i], 28'h000_0000, 24'h00_0000);
      cmd(`ASPG_CMD_VARIED_TWO);
      t0 = cyc;
      poll(3'h3);
      chk_near(cyc - t0, acc[i], 8);
      rd(`ASPG_OFS_SPEED_NOW);
      chk(q, 32'h0000_2008);
      cmd(`ASPG_CMD_STOP_DECEL);
      t0 = cyc;
      poll(3'h0);
      chk_near(cyc - t0, acc[i], 8);
    end
    for (int i = 0; i < 2; i++)
    begin
      // The host picks manual ramp-down for these short moves.
      cfg(i ? 3'h3 : 3'h1, 16'h2008, 15'h0000, 28'h000_0014, 24'h00_0006);
      p0 = pulses;
      cmd(i ? `ASPG_CMD_VARIED_TWO : `ASPG_CMD_VARIED_ONE);
      poll(3'h4);
      rd(`ASPG_OFS_REMAIN);
      chk_near(q, 5, 1);
      poll(3'h0);
      chk_near(pulses - p0, 20, 0);
    end
    // Automatic ramp-down: two accel pulses weigh 4, so decel starts at 2 left.
    cfg(3'h1, 16'h2008, 15'h0000, 28'h000_0014, 24'h00_0000);
    p0 = pulses;
    cmd(`ASPG_CMD_VARIED_TWO);
    poll(3'h4);
    rd(`ASPG_OFS_REMAIN);
    chk_near(q, 2, 1);
    poll(3'h0);
    chk_near(pulses - p0, 20, 0);
    cmd(`ASPG_CMD_CONST_HIGH);
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk({31'h0000_0000, busy}, 32'h0000_0000);
    rd(`ASPG_OFS_HIGH_SPEED);
    chk(q, 32'h0000_0001);
    stop_test();
  end
endmodule // tb_axis_speed_profile_generator
